// >>> core/error_record_status_fields.sv
// Purpose: primary status fields of one error record
// Assumes: register written/read through a plain 64-bit word port
// Notes: error-recovery reset preserves all state, so it has no effect
`timescale 1ns/1ps

module error_record_status_fields #(
  parameter bit HAS_CE_COUNTER = 1'b0,
  parameter bit HAS_CE_SEVERITY = 1'b0,
  parameter bit HAS_MISC = 1'b1,
  parameter bit HAS_FAULT_INJECT = 1'b0,
  parameter logic [7:0] IMPL_MAX = 8'h0f
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic recovery_reset,
  input wire err_status_pkg::error_event_s rec,
  input wire logic counter_overflow,
  input wire logic inject_code_capable,
  input wire logic wr_en,
  input wire logic [63:0] wr_data,
  output logic [63:0] rd_data,
  output logic counter_ovf_disturb
);
  logic holds_reg;
  logic uncorr_reg;
  logic inband_reg;
  logic ovf_reg;
  logic misc_reg;
  logic [1:0] ce_reg;
  logic defer_reg;
  logic poison_reg;
  logic [1:0] uet_reg;
  logic crit_reg;
  logic [7:0] impl_reg;
  logic [7:0] prim_reg;
  logic [63:0] view;
  logic impl_rw;
  logic [1:0] ce_code;
  logic [1:0] ce_wr;
  logic [1:0] uet_wr;

  // Write-one strobes per field, masked by field validity
  wire logic w_valid = wr_en && wr_data[err_status_pkg::VALID_BIT];
  wire logic w_uncorr = wr_en && holds_reg && wr_data[err_status_pkg::UNCORR_BIT];
  wire logic w_inband = wr_en && holds_reg && uncorr_reg &&
                        wr_data[err_status_pkg::INBAND_BIT];
  wire logic w_ovf = wr_en && holds_reg && wr_data[err_status_pkg::OVF_BIT];
  wire logic w_misc = wr_en && wr_data[err_status_pkg::MISC_BIT];
  wire logic w_defer = wr_en && holds_reg && wr_data[err_status_pkg::DEFER_BIT];
  wire logic w_poison = wr_en && holds_reg && (defer_reg || uncorr_reg) &&
                        wr_data[err_status_pkg::POISON_BIT];
  wire logic w_crit = wr_en && holds_reg && wr_data[err_status_pkg::CRIT_BIT];

  assign ce_wr = wr_data[err_status_pkg::CE_LSB +: 2];
  assign uet_wr = wr_data[err_status_pkg::UET_LSB +: 2];
  assign impl_rw = holds_reg || (HAS_FAULT_INJECT && inject_code_capable);

  // Kind of a new corrected error; severity only when the node can tell
  always_comb begin
    if (!HAS_CE_SEVERITY) begin
      ce_code = err_status_pkg::CE_PLAIN;
    end else if (rec.persistent) begin
      ce_code = err_status_pkg::CE_PERSISTENT;
    end else begin
      ce_code = err_status_pkg::CE_TRANSIENT;
    end
  end

  // Record valid; set wins over a same-cycle clear
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      holds_reg <= 1'b0;
    end else if (rec.valid) begin
      holds_reg <= 1'b1;
    end else if (w_valid) begin
      holds_reg <= 1'b0;
    end
  end

  // Uncorrected flag
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      uncorr_reg <= 1'b0;
    end else if (rec.valid && rec.uncorrected) begin
      uncorr_reg <= 1'b1;
    end else if (w_uncorr) begin
      uncorr_reg <= 1'b0;
    end
  end

  // In-band response flag
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      inband_reg <= 1'b0;
    end else if (rec.valid && rec.inband) begin
      inband_reg <= 1'b1;
    end else if (w_inband) begin
      inband_reg <= 1'b0;
    end
  end

  // Overflow: a second record, except a counted corrected one, means a syndrome was discarded
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ovf_reg <= 1'b0;
    end else if (HAS_CE_COUNTER && counter_overflow) begin
      ovf_reg <= 1'b1;
    end else if (rec.valid && holds_reg && (!rec.corrected || !HAS_CE_COUNTER)) begin
      ovf_reg <= 1'b1;
    end else if (w_ovf) begin
      ovf_reg <= 1'b0;
    end
  end

  // Counter may lose its own overflow when ours is cleared by software
  assign counter_ovf_disturb = HAS_CE_COUNTER && w_ovf;

  // Misc-info valid exists only when the record carries extra info
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      misc_reg <= 1'b0;
    end else if (HAS_MISC && rec.valid && rec.misc_info) begin
      misc_reg <= 1'b1;
    end else if (w_misc) begin
      misc_reg <= 1'b0;
    end
  end

  // Corrected kind; a mixed write keeps the value, one legal unknown
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ce_reg <= err_status_pkg::RESET_KIND;
    end else if (rec.valid && rec.corrected) begin
      ce_reg <= ce_code;
    end else if (wr_en && holds_reg && ce_wr == 2'h3) begin
      ce_reg <= err_status_pkg::CE_NONE;
    end
  end

  // Deferred flag
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      defer_reg <= 1'b0;
    end else if (rec.valid && rec.deferred) begin
      defer_reg <= 1'b1;
    end else if (w_defer) begin
      defer_reg <= 1'b0;
    end
  end

  // Poison only counts for uncorrected or deferred errors
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      poison_reg <= 1'b0;
    end else if (rec.valid && rec.poison && (rec.uncorrected || rec.deferred)) begin
      poison_reg <= 1'b1;
    end else if (w_poison) begin
      poison_reg <= 1'b0;
    end
  end

  // Uncorrected kind follows the latest uncorrected error
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      uet_reg <= err_status_pkg::RESET_KIND;
    end else if (rec.valid && rec.uncorrected) begin
      uet_reg <= rec.uncorr_kind;
    end else if (wr_en && holds_reg && uncorr_reg && uet_wr == 2'h3) begin
      uet_reg <= err_status_pkg::KIND_UNCONTAINABLE;
    end
  end

  // Critical flag
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      crit_reg <= 1'b0;
    end else if (rec.valid && rec.critical) begin
      crit_reg <= 1'b1;
    end else if (w_crit) begin
      crit_reg <= 1'b0;
    end
  end

  // Impl code: unsupported writes land as zero, one legal unknown
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      impl_reg <= err_status_pkg::RESET_CODE;
    end else if (rec.valid) begin
      impl_reg <= rec.impl;
    end else if (wr_en && impl_rw) begin
      if (wr_data[err_status_pkg::IMPL_LSB +: 8] <= IMPL_MAX) begin
        impl_reg <= wr_data[err_status_pkg::IMPL_LSB +: 8];
      end else begin
        impl_reg <= err_status_pkg::RESET_CODE;
      end
    end
  end

  // Primary code comes from the detector; a software write replaces it, but a same-cycle record wins
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prim_reg <= err_status_pkg::PRIM_NO_ERROR;
    end else if (rec.valid) begin
      prim_reg <= rec.primary;
    end else if (wr_en) begin
      prim_reg <= wr_data[err_status_pkg::PRIM_LSB +: 8];
    end
  end

  // Read view; fields without valid content read zero
  always_comb begin
    view = 64'h0;
    view[err_status_pkg::VALID_BIT] = holds_reg;
    view[err_status_pkg::UNCORR_BIT] = holds_reg && uncorr_reg;
    view[err_status_pkg::INBAND_BIT] = holds_reg && uncorr_reg && inband_reg;
    view[err_status_pkg::OVF_BIT] = holds_reg && ovf_reg;
    view[err_status_pkg::MISC_BIT] = HAS_MISC && misc_reg;
    view[err_status_pkg::CE_LSB +: 2] = holds_reg ? ce_reg : 2'h0;
    view[err_status_pkg::DEFER_BIT] = holds_reg && defer_reg;
    view[err_status_pkg::POISON_BIT] = holds_reg && (defer_reg || uncorr_reg) &&
                                       poison_reg;
    view[err_status_pkg::UET_LSB +: 2] = (holds_reg && uncorr_reg) ? uet_reg : 2'h0;
    view[err_status_pkg::CRIT_BIT] = holds_reg && crit_reg;
    view[err_status_pkg::IMPL_LSB +: 8] = impl_rw ? impl_reg : 8'h00;
    view[err_status_pkg::PRIM_LSB +: 8] = prim_reg;
  end

  // Registered read data; recovery reset deliberately changes nothing
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_data <= 64'h0;
    end else begin
      rd_data <= view;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Flag checks; cold reset cycles excluded except for the reset check itself
  holds_set_a: assert property (rec.valid |=> holds_reg)
    else $error("record valid not set");
  ovf_second_a: assert property (
    rec.valid && holds_reg && !rec.corrected |=> ovf_reg ##1 rd_data[27])
    else $error("overflow not raised on second record");
  cnt_ovf_a: assert property (HAS_CE_COUNTER && counter_overflow |=> ovf_reg)
    else $error("counter overflow not recorded");
  ce_plain_a: assert property (
    rec.valid && rec.corrected && !HAS_CE_SEVERITY |=> ce_reg == 2'h2)
    else $error("corrected kind not plain");
  ce_keep_a: assert property (
    !rec.valid && wr_en && ce_wr == 2'h0 |=> $stable(ce_reg))
    else $error("corrected kind changed by zero write");
  // Must see the reset cycles, so the default disable is switched off here
  mv_cold_a: assert property (
    @(posedge sys_clk) disable iff (1'b0) !reset_n |=> !misc_reg)
    else $error("misc valid not cleared by cold reset");
  // Recovery reset is a no-op; with no record, write or counter overflow, any state change under it is a fault
  recovery_keep_a: assert property (
    recovery_reset && !rec.valid && !wr_en && !counter_overflow |=>
      $stable({holds_reg, uncorr_reg, inband_reg, ovf_reg, misc_reg, ce_reg, defer_reg,
               poison_reg, uet_reg, crit_reg, impl_reg, prim_reg}))
    else $error("state changed across recovery reset");
  poison_set_a: assert property (
    rec.valid && rec.poison && rec.uncorrected |=> ##1 rd_data[22])
    else $error("poison flag missing");
  ovf_hidden_a: assert property (!holds_reg |=> !rd_data[27])
    else $error("overflow visible while record empty");
  uet_hidden_a: assert property (!uncorr_reg |=> rd_data[21:20] == 2'h0)
    else $error("uncorrected kind visible");
  crit_clear_a: assert property (
    w_crit && !rec.valid |=> !crit_reg)
    else $error("critical flag not cleared");
  crit_wins_a: assert property (
    rec.valid && rec.critical && w_crit |=> crit_reg)
    else $error("critical event lost to clear");

  second_rec_c: cover property (rec.valid ##[1:4] rec.valid ##1 ovf_reg);
  clear_all_c: cover property (holds_reg ##1 w_valid ##1 !holds_reg);
  set_vs_clear_c: cover property (rec.valid && w_valid);
endmodule

// >>> core/err_status_pkg.sv
// Purpose: constants and carriers for the error record status block
// Assumes: one 64-bit status word, bits 63:31 and 18:16 reserved
// Notes: fields read as zero where their content is not valid
package err_status_pkg;
  // Field positions in the status word
  localparam int unsigned VALID_BIT = 30;
  localparam int unsigned UNCORR_BIT = 29;
  localparam int unsigned INBAND_BIT = 28;
  localparam int unsigned OVF_BIT = 27;
  localparam int unsigned MISC_BIT = 26;
  localparam int unsigned CE_LSB = 24;
  localparam int unsigned DEFER_BIT = 23;
  localparam int unsigned POISON_BIT = 22;
  localparam int unsigned UET_LSB = 20;
  localparam int unsigned CRIT_BIT = 19;
  localparam int unsigned IMPL_LSB = 8;
  localparam int unsigned PRIM_LSB = 0;

  // Corrected-error kinds
  localparam logic [1:0] CE_NONE = 2'h0;
  localparam logic [1:0] CE_TRANSIENT = 2'h1;
  localparam logic [1:0] CE_PLAIN = 2'h2;
  localparam logic [1:0] CE_PERSISTENT = 2'h3;

  // Uncorrected-error kinds
  localparam logic [1:0] KIND_UNCONTAINABLE = 2'h0;
  localparam logic [1:0] KIND_UNRECOVERABLE = 2'h1;
  localparam logic [1:0] KIND_LATENT_RESTARTABLE = 2'h2;
  localparam logic [1:0] KIND_SIGNALED_RECOVERABLE = 2'h3;

  // Primary codes, first two and last of the defined range
  localparam logic [7:0] PRIM_NO_ERROR = 8'h00;
  localparam logic [7:0] PRIM_IMPL = 8'h01;
  localparam logic [7:0] PRIM_OTHER_INTERNAL = 8'h1a;

  // Values after cold reset (unknown fields are given zero)
  localparam logic [7:0] RESET_CODE = 8'h00;
  localparam logic [1:0] RESET_KIND = 2'h0;

  // One recorded error from the node's detection logic
  typedef struct packed {
    logic valid;
    logic corrected;
    logic deferred;
    logic uncorrected;
    logic persistent;
    logic poison;
    logic critical;
    logic inband;
    logic misc_info;
    logic [1:0] uncorr_kind;
    logic [7:0] impl;
    logic [7:0] primary;
  } error_event_s;
endpackage

// >>> tb/error_record_status_fields_tb.sv
// Purpose: self-checking bench for the error record status fields
// Assumes: main instance with fault injection, second with counter and severity
// Notes: inputs change on the falling edge; rd_data is checked two edges later
`timescale 1ns/1ps
module error_record_status_fields_tb;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic recovery_reset = 1'b0;
  err_status_pkg::error_event_s rec = '0;
  logic counter_overflow = 1'b0;
  logic inject_code_capable = 1'b0;
  logic wr_en = 1'b0;
  logic [63:0] wr_data = 64'h0;
  logic [63:0] rd_data;
  logic counter_ovf_disturb;
  logic [63:0] rd_data_cnt;
  logic disturb_cnt;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  error_record_status_fields #(.HAS_FAULT_INJECT(1'b1)) i_dut (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .recovery_reset(recovery_reset),
    .rec(rec),
    .counter_overflow(counter_overflow),
    .inject_code_capable(inject_code_capable),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .counter_ovf_disturb(counter_ovf_disturb)
  );

  // Variant with a corrected-error counter and transient/persistent detection
  error_record_status_fields #(.HAS_CE_COUNTER(1'b1), .HAS_CE_SEVERITY(1'b1)) i_dut_cnt (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .recovery_reset(recovery_reset),
    .rec(rec),
    .counter_overflow(counter_overflow),
    .inject_code_capable(inject_code_capable),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .rd_data(rd_data_cnt),
    .counter_ovf_disturb(disturb_cnt)
  );

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // Hang guard, far above the roughly 75 cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      $display("MISMATCH at %0t: run did not finish in time", $time);
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One recorded error; returns when rd_data shows it
  task automatic ev(input logic corr, def, unc, poi, crit, inb, mis,
                    input logic [1:0] k, input logic [7:0] im, pr);
    @(negedge sys_clk);
    rec = err_status_pkg::error_event_s'({1'b1, corr, def, unc, 1'b0, poi, crit, inb, mis,
                                          k, im, pr});
    @(negedge sys_clk);
    rec = '0;
    @(negedge sys_clk);
  endtask

  // One register write; returns when rd_data shows it
  task automatic wr(input logic [63:0] d);
    @(negedge sys_clk);
    wr_en = 1'b1;
    wr_data = d;
    @(negedge sys_clk);
    wr_en = 1'b0;
    wr_data = 64'h0;
    @(negedge sys_clk);
  endtask

  // Masked compare of a status word
  task automatic chk_word(input logic [63:0] got, input logic [63:0] mask,
                          input logic [63:0] exp, input string what);
    n_compared++;
    if ((got & mask) !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %h want %h", $time, what, got & mask, exp);
    end
  endtask

  // Main instance's status word
  task automatic chk(input logic [63:0] mask, input logic [63:0] exp, input string what);
    chk_word(rd_data, mask, exp, what);
  endtask

  // One-bit strobe, looked at while it stands
  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic test_end(input string name);
    $display("test %s done, mismatches so far %0d", name, num_errors);
  endtask

  initial begin
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    chk('1, 64'h0, "cold reset");
    test_end("reset");

    // Uncorrected, poisoned, critical error with extra info
    ev(0, 0, 1, 1, 1, 1, 1, 2'h3, 8'h05, 8'h13);
    chk('1, 64'h0000_0000_7478_0513, "first record");
    // Counterless corrected error on a valid record overflows, kind 10
    ev(1, 0, 0, 0, 0, 0, 0, 2'h0, 8'h05, 8'h13);
    chk(64'h2b00_0000, 64'h2a00_0000, "corrected overflow");
    chk('1, 64'h0000_0000_7e78_0513, "kind plain");
    test_end("record");

    // Zero write changes nothing, recovery reset keeps everything
    wr(64'h0000_0000_0000_0513);
    chk('1, 64'h0000_0000_7e78_0513, "zero write");
    @(negedge sys_clk);
    recovery_reset = 1'b1;
    @(negedge sys_clk);
    recovery_reset = 1'b0;
    @(negedge sys_clk);
    chk('1, 64'h0000_0000_7e78_0513, "recovery reset");
    test_end("keep");

    // Mixed corrected-kind write keeps, all-ones uncorrected-kind write clears, overflow one-to-clear
    wr(64'h0000_0000_0100_0513);
    chk('1, 64'h0000_0000_7e78_0513, "mixed kind");
    wr(64'h0000_0000_0830_0513);
    chk('1, 64'h0000_0000_7648_0513, "clear kind and overflow");
    // Code fields: legal and unsupported implementation codes
    wr(64'h0000_0000_0000_0a19);
    chk('1, 64'h0000_0000_7648_0a19, "impl write");
    wr(64'h0000_0000_0000_2019);
    chk(64'hff00, 64'h0, "impl unsupported");
    wr(64'h0000_0000_0000_0a19);
    test_end("write");

    // Software clears every flag and kind together with the valid bit; the codes stay
    wr(64'h0000_0000_7ff8_0a19);
    chk('1, 64'h0000_0000_0000_0019, "cleared record");
    inject_code_capable = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk('1, 64'h0000_0000_0000_0a19, "impl with injection");
    inject_code_capable = 1'b0;
    test_end("clear");

    // Deferred poisoned error on an empty record: no overflow
    ev(0, 1, 0, 1, 0, 0, 0, 2'h0, 8'h03, 8'h17);
    chk('1, 64'h0000_0000_40c0_0317, "deferred poison");
    // Every uncorrected kind, each overflowing a valid record
    for (int k = 0; k < 4; k++) begin
      ev(0, 0, 1, 0, 0, 0, 0, k[1:0], 8'h03, 8'h0c);
      chk(64'h2830_0000, 64'h2800_0000 | (64'(k) << 20), "uncorrected kind");
    end
    test_end("kinds");

    // Cold reset in mid-run zeroes the word
    @(negedge sys_clk);
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    chk('1, 64'h0, "second cold reset");
    test_end("cold");

    // Two corrected errors: counterless overflows, counted one does not
    ev(1, 0, 0, 0, 0, 0, 0, 2'h0, 8'h00, 8'h05);
    ev(1, 0, 0, 0, 0, 0, 0, 2'h0, 8'h00, 8'h05);
    chk(64'h0b00_0000, 64'h0a00_0000, "counterless second corrected");
    chk_word(rd_data_cnt, 64'h0b00_0000, 64'h0100_0000, "counted transient kind");
    // Counter overflow pulse reaches only the counter variant
    @(negedge sys_clk);
    counter_overflow = 1'b1;
    @(negedge sys_clk);
    counter_overflow = 1'b0;
    @(negedge sys_clk);
    chk_word(rd_data_cnt, 64'h0800_0000, 64'h0800_0000, "counter overflow");
    // Overflow clear strobes the counter disturb line while the write stands
    @(negedge sys_clk);
    wr_en = 1'b1;
    wr_data = 64'h0000_0000_0800_0000;
    #1;
    chk_bit(disturb_cnt, 1'b1, "disturb on overflow clear");
    chk_bit(counter_ovf_disturb, 1'b0, "no disturb without counter");
    @(negedge sys_clk);
    wr_en = 1'b0;
    wr_data = 64'h0;
    @(negedge sys_clk);
    chk_word(rd_data_cnt, 64'h0800_0000, 64'h0, "overflow cleared");
    // Critical event and its clear in one cycle: the event wins
    @(negedge sys_clk);
    rec = err_status_pkg::error_event_s'(27'h610_0000); // Valid, corrected, critical
    wr_en = 1'b1;
    wr_data = 64'h0000_0000_0008_0000;
    @(negedge sys_clk);
    rec = '0;
    wr_en = 1'b0;
    wr_data = 64'h0;
    @(negedge sys_clk);
    chk(64'h0008_0000, 64'h0008_0000, "critical set beats clear");
    test_end("counter");
    stop_test();
  end
endmodule
